// ---- verilog/sscr_top.sv ----
// Purpose: Status set/clear access registers over an internal status word
// Assumes: Classic Wishbone slave, 40 MHz peripheral clock, sync reset
// Notes:   Error conditions come from the bus clock domain as levels
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// What this block does
// - Reads of either register show software interrupt flags in 27-24.
// - Reads show parity error flag in bit 6, system error in 5.
// - Reads show master abort flag in bit 2, target abort in 1.
// - One written to set bits 27-24 raises the matching software flag.
// - Zero written to the set register leaves that flag unchanged.
// - Writing one to set bit 6 raises parity error flag.
// - Writing one to set bit 5 raises system error flag.
// - Writing one to set bit 2 raises master abort flag.
// - Writing one to set bit 1 raises target abort flag.
// - Clear write lowers a flag only once its hardware condition is gone.
// - Removed bus-domain condition shows removed after three clocks.
module sscr_top
  import sscr_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire sscr_pkg::sscr_wb_req_t wb_req_i,
  output logic                       wb_ack_o,
  output logic [31:0]                wb_dat_o,
  // Error conditions from the bus clock domain
  input  wire sscr_pkg::sscr_cond_t  cond_i,
  // Status towards the rest of the peripheral
  output logic [31:0]                status_flags_o,
  output logic                       irq_o
);

  import sscr_pkg::*;

  // Registers
  logic [31:0] flags;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  logic        ack;
  logic [31:0] rdata;

  // Synchronised conditions
  logic [SSCR_COND_W-1:0] cond_sync;
  sscr_cond_t             cond_s;

  // Next values
  logic [31:0] next_flags;
  logic [31:0] next_irq_status;
  logic [31:0] next_irq_mask;
  logic [31:0] next_rdata;

  // Bus decode
  wire         req        = wb_req_i.cyc & wb_req_i.stb;
  wire         req_start  = req & ~ack;
  wire         wr_commit  = req & ack & wb_req_i.we;
  wire         hit_set    = wb_req_i.adr == SSCR_OFS_SET;
  wire         hit_clr    = wb_req_i.adr == SSCR_OFS_CLR;
  wire         hit_irq_st = wb_req_i.adr == SSCR_OFS_IRQ_ST;
  wire         hit_irq_mk = wb_req_i.adr == SSCR_OFS_IRQ_MSK;
  wire         hit_cond   = wb_req_i.adr == SSCR_OFS_COND;

  // Byte lanes widened to a bit mask
  wire  [31:0] lane_mask  = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                             {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  wire  [31:0] wdata      = wb_req_i.dat & lane_mask;

  // Three flops before any logic looks at the foreign levels
  sscr_sync #(
    .W      (SSCR_COND_W),
    .STAGES (SSCR_SYNC_STAGES)
  ) u_cond_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .async_i(cond_i),
    .sync_o (cond_sync)
  );

  assign cond_s = sscr_cond_t'(cond_sync);

  // Hardware conditions placed at their flag positions
  logic [31:0] hw_cond;
  always_comb begin
    hw_cond                 = 32'h0000_0000;
    hw_cond[SSCR_BIT_PERR]  = cond_s.parity_error;
    hw_cond[SSCR_BIT_SERR]  = cond_s.system_error;
    hw_cond[SSCR_BIT_MABRT] = cond_s.master_abort;
    hw_cond[SSCR_BIT_TABRT] = cond_s.target_abort;
  end

  // Set strobes: only implemented bits; bit 31 and other reserved
  // bits are dropped so a careless write cannot create state
  wire  [31:0] set_wr  = (wr_commit & hit_set)
                         ? (wdata & SSCR_FLAG_MASK)
                         : 32'h0000_0000;

  // Clear strobes are blocked while the condition still holds
  wire  [31:0] clr_wr  = (wr_commit & hit_clr)
                         ? (wdata & SSCR_FLAG_MASK & ~hw_cond)
                         : 32'h0000_0000;

  // Software interrupt flags
  wire  [31:0] soft_set = set_wr & SSCR_SOFT_MASK;

  // Error flags raised by software, as if detected
  wire         perr_sw  = set_wr[SSCR_BIT_PERR];
  wire         serr_sw  = set_wr[SSCR_BIT_SERR];
  wire         mabrt_sw = set_wr[SSCR_BIT_MABRT];
  wire         tabrt_sw = set_wr[SSCR_BIT_TABRT];

  logic [31:0] err_sw;
  always_comb begin
    err_sw                 = 32'h0000_0000;
    err_sw[SSCR_BIT_PERR]  = perr_sw;
    err_sw[SSCR_BIT_SERR]  = serr_sw;
    err_sw[SSCR_BIT_MABRT] = mabrt_sw;
    err_sw[SSCR_BIT_TABRT] = tabrt_sw;
  end

  // Any set source wins over a clear in the same cycle
  assign next_flags = ((flags & ~clr_wr) | soft_set | err_sw | hw_cond)
                      & SSCR_FLAG_MASK;

  // Interrupt bookkeeping: a flag going high is the event
  wire  [31:0] flag_rise  = next_flags & ~flags;
  wire  [31:0] irq_clr    = (wr_commit & hit_irq_st)
                            ? (wdata & SSCR_FLAG_MASK)
                            : 32'h0000_0000;
  assign next_irq_status  = ((irq_status & ~irq_clr) | flag_rise)
                            & SSCR_FLAG_MASK;

  // Mask writes honour byte lanes
  wire         mask_wr    = wr_commit & hit_irq_mk;
  assign next_irq_mask    = mask_wr
                            ? (((irq_mask & ~lane_mask) | wdata)
                               & SSCR_FLAG_MASK)
                            : irq_mask;

  // Read data is captured on the first cycle of a request; the flags
  // seen are those of that cycle, one clock before ack
  wire  [31:0] rd_flags   = flags & SSCR_FLAG_MASK;
  wire  [31:0] rd_cond    = hw_cond;
  wire  [31:0] rd_irq_st  = irq_status;
  wire  [31:0] rd_irq_mk  = irq_mask;

  assign next_rdata = (hit_set | hit_clr) ? rd_flags  :
                      hit_irq_st          ? rd_irq_st :
                      hit_irq_mk          ? rd_irq_mk :
                      hit_cond            ? rd_cond   :
                                            32'h0000_0000;

  // Internal status word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= SSCR_RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= SSCR_RST_IRQ;
      irq_mask   <= SSCR_RST_MASK;
    end else begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  // Bus answer: ack one cycle after the request, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= req_start;
      if (req_start) begin
        rdata <= next_rdata;
      end
    end
  end

  assign wb_ack_o       = ack;
  assign wb_dat_o       = rdata;
  assign status_flags_o = flags;
  assign irq_o          = |(irq_status & irq_mask);

endmodule

// ---- verilog/sscr_pkg.sv ----
// Purpose: Shared constants and types for the status set/clear bank
// Assumes: 32-bit classic Wishbone, word aligned registers
// Notes:   Offsets are byte addresses on the register bus
package sscr_pkg;

  // Register byte offsets
  localparam logic [31:0] SSCR_OFS_SET     = 32'h0000_0000;
  localparam logic [31:0] SSCR_OFS_CLR     = 32'h0000_0004;
  localparam logic [31:0] SSCR_OFS_IRQ_ST  = 32'h0000_0008;
  localparam logic [31:0] SSCR_OFS_IRQ_MSK = 32'h0000_000C;
  localparam logic [31:0] SSCR_OFS_COND    = 32'h0000_0010;

  // Field positions in the status layout
  localparam int SSCR_BIT_WR_ZERO  = 31;
  localparam int SSCR_BIT_SOFT_LO  = 24;
  localparam int SSCR_SOFT_W       = 4;
  localparam int SSCR_BIT_PERR     = 6;
  localparam int SSCR_BIT_SERR     = 5;
  localparam int SSCR_BIT_MABRT    = 2;
  localparam int SSCR_BIT_TABRT    = 1;

  // Implemented flag bits, everything else reads zero
  localparam logic [31:0] SSCR_FLAG_MASK  = 32'h0F00_0066;
  localparam logic [31:0] SSCR_SOFT_MASK  = 32'h0F00_0000;

  // Reset values
  localparam logic [31:0] SSCR_RST_FLAGS  = 32'h0000_0000;
  localparam logic [31:0] SSCR_RST_IRQ    = 32'h0000_0000;
  localparam logic [31:0] SSCR_RST_MASK   = 32'h0000_0000;

  // Condition synchroniser depth, in peripheral clocks
  localparam int SSCR_SYNC_STAGES = 3;
  localparam int SSCR_COND_W      = 4;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sscr_wb_req_t;

  // Error conditions arriving from the bus clock domain
  typedef struct packed {
    logic parity_error;
    logic system_error;
    logic master_abort;
    logic target_abort;
  } sscr_cond_t;

endpackage

// ---- verilog/sscr_sync.sv ----
// Purpose: Multi-stage level synchroniser for foreign-domain conditions
// Assumes: Inputs are levels held long enough to be seen
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
module sscr_sync #(
  parameter int W      = 4,
  parameter int STAGES = 3
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage [STAGES];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= async_i;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign sync_o = stage[STAGES-1];

endmodule

// ---- dv/sscr_checker.sv ----
// Purpose: Port-level checks for the status set/clear bank
// Assumes: Writes use all byte lanes
// Notes:   Bound onto sscr_top at the foot of this file
`timescale 1ns/1ps
module sscr_checker
  import sscr_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Watched ports
  input  wire sscr_pkg::sscr_wb_req_t wb_req_i,
  input  wire logic                   wb_ack_o,
  input  wire logic [31:0]            wb_dat_o,
  input  wire sscr_pkg::sscr_cond_t   cond_i,
  input  wire logic [31:0]            status_flags_o,
  input  wire logic                   irq_o
);
  logic [2:0]  quiet;
  wire  [31:0] f  = status_flags_o;
  wire  [31:0] ad = wb_req_i.adr;
  wire  [31:0] wd = wb_req_i.dat & SSCR_FLAG_MASK;
  wire         rq = wb_req_i.cyc && wb_req_i.stb;
  wire         wa = wb_ack_o && wb_req_i.we;
  wire         ws = wa && ad == SSCR_OFS_SET && wb_req_i.sel == 4'hF;
  wire         wc = wa && ad == SSCR_OFS_CLR && wb_req_i.sel == 4'hF;
  wire         rd = rq && !wb_ack_o && !wb_req_i.we &&
                    (ad == SSCR_OFS_SET || ad == SSCR_OFS_CLR);

  // Long quiet window so the clear check never races the synchroniser
  always_ff @(posedge clk_i)
    if (rst_i || cond_i != '0) quiet <= '0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_latency: assert property (rq && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_resv_zero: assert property ((f & ~SSCR_FLAG_MASK) == '0)
    else $error("reserved flag bit set");
  a_read_flags: assert property (rd |=> wb_dat_o == $past(f))
    else $error("read data differs from flags");
  a_set_bits:
    assert property (ws |=> (f & $past(wd)) == $past(wd))
    else $error("set write missed a flag");
  a_no_fall:
    assert property (!(wa && ad == SSCR_OFS_CLR)
                     |=> (f & $past(f)) == $past(f))
    else $error("flag fell without a clear");
  a_clear_bits:
    assert property (wc && quiet == 3'h7 |=> (f & $past(wd)) == '0)
    else $error("clear write ignored");
  a_hw_perr:
    assert property (cond_i.parity_error [*4] |=> f[SSCR_BIT_PERR])
    else $error("parity flag not held");
  a_hw_tabrt:
    assert property (cond_i.target_abort [*4] |=> f[SSCR_BIT_TABRT])
    else $error("target abort flag not held");

  c_set: cover property (ws);
  c_clr_blocked: cover property (wc && cond_i != '0);
  c_irq: cover property (irq_o);
endmodule

bind sscr_top sscr_checker u_sscr_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .cond_i(cond_i), .status_flags_o(status_flags_o),
  .irq_o(irq_o)
);

// ---- dv/status_set_clear_regs_tb.sv ----
// Purpose: Self-checking bench for the status set/clear bank
// Assumes: Registered ack, read data taken from the start edge
// Notes:   Interrupt registers at the package offsets
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  num_errors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module status_set_clear_regs_tb;
  import sscr_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  sscr_wb_req_t r     = '0;
  sscr_cond_t   c     = '0;
  logic         ack;
  logic         irq;
  logic [31:0]  dat;
  logic [31:0]  flags;
  logic [31:0]  q;
  int           num_errors  = 0;
  int           check_count = 0;

  always #12.5 clk_i = ~clk_i;

  sscr_top u_sscr_top (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .wb_req_i       (r),
    .wb_ack_o       (ack),
    .wb_dat_o       (dat),
    .cond_i         (c),
    .status_flags_o (flags),
    .irq_o          (irq)
  );

  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Request held until ack is sampled; the next call leaves one idle cycle
  task automatic bus(input logic        w,
                     input logic [31:0] a,
                     input logic [31:0] d);
    int   n;
    logic got;
    n = 0;
    @(posedge clk_i);
    r <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    got = ack;
    q = dat;
    r.cyc <= 1'b0;
    r.stb <= 1'b0;
    #1;
    if (got !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, 1'b1);
      wrap_up();
    end
  endtask

  task automatic t_set;
    int          bits[8] = '{27, 26, 25, 24, 6, 5, 2, 1};
    logic [31:0] exp;
    exp = '0;
    foreach (bits[i]) begin
      bus(1'b1, SSCR_OFS_SET, 32'h1 << bits[i]);
      exp[bits[i]] = 1'b1;
      `CHK(flags, exp)
    end
    bus(1'b1, SSCR_OFS_SET, '0);
    bus(1'b0, SSCR_OFS_CLR, '0);
    `CHK(q, SSCR_FLAG_MASK)
    bus(1'b1, SSCR_OFS_CLR, 32'h0F00_0006);
    bus(1'b0, SSCR_OFS_SET, '0);
    `CHK(q, 32'h0000_0060)
    bus(1'b1, 32'h0000_0020, '1);
    bus(1'b0, 32'h0000_0020, '0);
    `CHK(q, 32'h0000_0000)
    `CHK(flags, 32'h0000_0060)
  endtask

  task automatic t_hw;
    bus(1'b1, SSCR_OFS_CLR, SSCR_FLAG_MASK);
    @(posedge clk_i);
    c <= '1;
    repeat (6) @(posedge clk_i);
    bus(1'b1, SSCR_OFS_CLR, SSCR_FLAG_MASK);
    `CHK(flags, 32'h0000_0066)
    @(posedge clk_i);
    c <= '0;
    bus(1'b1, SSCR_OFS_CLR, SSCR_FLAG_MASK);
    `CHK(flags, 32'h0000_0066)
    bus(1'b1, SSCR_OFS_CLR, SSCR_FLAG_MASK);
    `CHK(flags, 32'h0000_0000)
  endtask

  task automatic t_irq;
    bus(1'b1, SSCR_OFS_IRQ_ST, '1);
    bus(1'b1, SSCR_OFS_SET, 32'h0200_0000);
    `CHK(irq, 1'b0)
    bus(1'b1, SSCR_OFS_IRQ_MSK, 32'h0200_0000);
    `CHK(irq, 1'b1)
    bus(1'b0, SSCR_OFS_IRQ_MSK, '0);
    `CHK(q, 32'h0200_0000)
    bus(1'b1, SSCR_OFS_IRQ_ST, 32'h0200_0000);
    `CHK(irq, 1'b0)
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK(flags, SSCR_RST_FLAGS)
    t_set();
    t_hw();
    t_irq();
    wrap_up();
  end
endmodule
